// ### hw/phase_shift_bridge_sequencer.sv
/*
 * output sequencer of a phase shifted full bridge: four bridge drives and
 * two rectifier drives stepped through pulse, active transition, freewheel
 * and passive transition. assumes every input but clock and reset is an asynchronous pin and
 * the external gate drivers follow the drive levels.
 */
`timescale 1ns/1ns

module phase_shift_bridge_sequencer
    import psb_pkg::*;
#(
    parameter int COMMUTATE_CYC = COMMUTATE_LIMIT_CYC
) (
    // clock and reset
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    // analog outcomes, asynchronous
    input  wire logic          osc_clock_i,
    input  wire logic          phase_cmp_i,
    input  wire logic          active_leg_sense_i,
    input  wire logic          passive_leg_sense_i,
    input  wire logic          bus_voltage_sense_tied_i,
    // gate driver side
    output bridge_drive_t      drive_o,
    output logic               phase_o
);

    localparam int CW = $clog2(COMMUTATE_CYC + 1);
    localparam int A_WAIT_MAX = COMMUTATE_CYC + 2;

    logic [SYNC_WIDTH-1:0] sync1_q;
    logic [SYNC_WIDTH-1:0] sync2_q;
    logic [SYNC_WIDTH-1:0] pins;
    logic                  osc_prev_q;
    logic                  cmp_prev_q;
    logic                  osc_rise;
    logic                  cmp_rise;
    logic                  act_sense;
    logic                  pas_sense;
    logic                  zero_mode;
    seq_state_t            state_q;
    seq_state_t            state_d;
    logic                  phase_q;
    logic                  phase_d;
    logic                  osc_pend_q;
    logic                  osc_go;
    logic [CW-1:0]         wait_cnt_q;
    logic                  timeout;
    logic                  act_ok;
    logic                  pas_ok;
    bridge_drive_t         drive_q;

    assign pins = {bus_voltage_sense_tied_i, passive_leg_sense_i,
                   active_leg_sense_i, phase_cmp_i, osc_clock_i};

    // two flops per pin before any logic looks at it
    generate
        for (genvar i = 0; i < SYNC_WIDTH; i++) begin : g_sync
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    sync1_q[i] <= 1'b0;
                    sync2_q[i] <= 1'b0;
                end else begin
                    sync1_q[i] <= pins[i];
                    sync2_q[i] <= sync1_q[i];
                end
            end
        end
    endgenerate

    // edge history for clock and comparator events
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            osc_prev_q <= 1'b0;
            cmp_prev_q <= 1'b0;
        end else begin
            osc_prev_q <= sync2_q[0];
            cmp_prev_q <= sync2_q[1];
        end
    end

    assign osc_rise  = sync2_q[0] & ~osc_prev_q;
    assign cmp_rise  = sync2_q[1] & ~cmp_prev_q;
    assign act_sense = sync2_q[2];
    assign pas_sense = sync2_q[3];
    assign zero_mode = sync2_q[4];

    // a clock that lands in pulse or active transition is held until freewheel; one in passive transition is dropped
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            osc_pend_q <= 1'b0;
        end else if (osc_rise && (state_q == ST_PULSE || state_q == ST_ACT_TRANS)) begin
            osc_pend_q <= 1'b1;
        end else if (state_q == ST_FREEWHEEL) begin
            osc_pend_q <= 1'b0;
        end
    end

    assign osc_go = osc_rise | osc_pend_q;

    // commutation watchdog, runs only while a leg is slewing
    always_ff @(posedge clk_i) begin
        if (rst_i || state_d != state_q) begin
            wait_cnt_q <= '0;
        end else if (state_q == ST_ACT_TRANS || state_q == ST_PAS_TRANS) begin
            wait_cnt_q <= wait_cnt_q + CW'(1);
        end
    end

    assign timeout = (wait_cnt_q == CW'(COMMUTATE_CYC - 1));

    // leg target level flips with the phase: rising when phase is 0 for
    // the active leg; the passive leg is judged after the toggle
    assign act_ok = zero_mode | timeout | (act_sense == ~phase_q);
    assign pas_ok = zero_mode | timeout | (pas_sense == ~phase_q);

    // sequence steps
    always_comb begin
        state_d = state_q;
        phase_d = phase_q;
        unique case (state_q)
            ST_PULSE: begin
                if (cmp_rise) begin
                    state_d = ST_ACT_TRANS;
                end
            end
            ST_ACT_TRANS: begin
                if (act_ok) begin
                    state_d = ST_FREEWHEEL;
                end
            end
            ST_FREEWHEEL: begin
                if (osc_go) begin
                    state_d = ST_PAS_TRANS;
                    phase_d = ~phase_q;
                end
            end
            ST_PAS_TRANS: begin
                if (pas_ok) begin
                    state_d = ST_PULSE;
                end
            end
        endcase
    end

    // state and toggle flip-flop
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= ST_PAS_TRANS;
            phase_q <= PHASE_RESET;
        end else begin
            state_q <= state_d;
            phase_q <= phase_d;
        end
    end

    // drive pattern per step; phase 1 swaps high, low and rectifier roles
    function automatic bridge_drive_t drive_for(seq_state_t s, logic p);
        bridge_drive_t d;
        d = DRIVE_RESET;
        unique case (s)
            ST_PULSE: begin
                d.passive_high_drive = ~p;
                d.passive_low_drive  = p;
                d.active_low_drive   = ~p;
                d.active_high_drive  = p;
                d.rectifier_drive_f  = ~p;
                d.rectifier_drive_e  = p;
            end
            ST_ACT_TRANS: begin
                d.passive_high_drive = ~p;
                d.passive_low_drive  = p;
                d.rectifier_drive_e  = 1'b1;
                d.rectifier_drive_f  = 1'b1;
            end
            ST_FREEWHEEL: begin
                d.passive_high_drive = ~p;
                d.active_high_drive  = ~p;
                d.passive_low_drive  = p;
                d.active_low_drive   = p;
                d.rectifier_drive_e  = 1'b1;
                d.rectifier_drive_f  = 1'b1;
            end
            ST_PAS_TRANS: begin
                // p already toggled here
                d.active_high_drive  = p;
                d.active_low_drive   = ~p;
                d.rectifier_drive_e  = p;
                d.rectifier_drive_f  = ~p;
            end
        endcase
        return d;
    endfunction

    // registered drives track the state flops exactly except in reset, where they load DRIVE_RESET
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            drive_q <= DRIVE_RESET;
        end else begin
            drive_q <= drive_for(state_d, phase_d);
        end
    end

    assign drive_o = drive_q;
    assign phase_o = phase_q;

    a_reset_quiet: assert property (@(posedge clk_i)
        rst_i |=> (drive_o == DRIVE_RESET && !phase_o))
        else $error("drives not off after reset");

    a_toggle_at_clock: assert property (@(posedge clk_i) disable iff (rst_i)
        (phase_q != $past(phase_q)) |-> ($past(state_q) == ST_FREEWHEEL && $past(osc_go)))
        else $error("toggle moved outside freewheel clock");

    a_passive_on_phase: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(drive_o.passive_high_drive) |-> !phase_q ##1 !drive_o.passive_low_drive)
        else $error("passive high rose in wrong phase");

    a_pulse1_pattern: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_q == ST_PULSE && !phase_q) |->
        (drive_o == bridge_drive_t'(6'h25)))
        else $error("first power pulse pattern wrong");

    a_pulse_end_cmp: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_q == ST_PULSE && cmp_rise && !phase_q) |=>
        (!drive_o.active_low_drive && drive_o.rectifier_drive_e && drive_o.passive_high_drive))
        else $error("pulse did not end on comparator");

    a_freewheel_rects: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_q == ST_FREEWHEEL) |->
        (drive_o.rectifier_drive_e && drive_o.rectifier_drive_f &&
         (phase_q ? (drive_o.passive_low_drive && drive_o.active_low_drive)
                  : (drive_o.passive_high_drive && drive_o.active_high_drive))))
        else $error("freewheel drives wrong");

    a_no_shoot_leg: assert property (@(posedge clk_i) disable iff (rst_i)
        !(drive_o.passive_high_drive && drive_o.passive_low_drive) &&
        !(drive_o.active_high_drive && drive_o.active_low_drive))
        else $error("leg shoot through");

    a_passive_off_clk: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(drive_o.passive_high_drive) |->
        ($past(osc_go) && !drive_o.rectifier_drive_f))
        else $error("passive high dropped without clock");

    a_act_sense_wait: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_q == ST_ACT_TRANS && !phase_q && !act_sense && !zero_mode && !timeout) |=>
        !drive_o.active_high_drive)
        else $error("active high before leg rose");

    a_force_bound: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(state_q == ST_PAS_TRANS) |-> ##[1:A_WAIT_MAX] (state_q != ST_PAS_TRANS))
        else $error("passive transition never forced");

    a_zero_mode_skip: assert property (@(posedge clk_i) disable iff (rst_i)
        (zero_mode && state_q == ST_ACT_TRANS) |=> (state_q == ST_FREEWHEEL))
        else $error("zero delay mode waited");

endmodule

// ### hw/psb_pkg.sv
/*
 * constants, types and state encoding of the phase shifted bridge
 * output sequencer. assumes one 100 MHz clock and a synchronous reset
 * that the supply lockout also drives.
 */
// Notes on behaviour
// - a toggle flip-flop swaps the conducting diagonal pair each oscillator cycle.
// - each bridge drive is active only every other oscillator cycle, so at half its rate.
// - each bridge drive is on for a little under half its period, trimmed by the sense waits.
// - the phase comparator sets how long both switches of a diagonal pair overlap.
// - the first power pulse drives passive high, active low and rectifier f, the rest off.
// - when the first power pulse ends, active low drops and rectifier e comes on.
// - the conducting active leg drive drops when the phase comparator trips.
// - after active low drops, active high waits until the active leg reaches the input rail.
// - in freewheel both rectifier drives are on together with both high side drives in phase 0, or both low side drives in phase 1.
// - freewheel ends with passive high and rectifier f dropping.
// - the conducting passive drive drops at the oscillator clock that toggles the flip-flop.
// - after passive high drops, passive low waits until the passive leg nears ground.
// - the second power pulse ends with active high dropping, a mirrored transition.
// - a leg that never commutates is forced on after a bounded wait.
// - with the bus sense tied to the reference, the sense waits are skipped.
package psb_pkg;

    localparam int   CLK_PERIOD_NS       = 10;
    // longest wait for a leg to commutate before forcing
    localparam int   COMMUTATE_LIMIT_NS  = 500;
    localparam int   COMMUTATE_LIMIT_CYC = COMMUTATE_LIMIT_NS / CLK_PERIOD_NS;
    localparam int   SYNC_WIDTH          = 5;
    localparam logic PHASE_RESET         = 1'b0;

    typedef enum {
        ST_PULSE,
        ST_ACT_TRANS,
        ST_FREEWHEEL,
        ST_PAS_TRANS
    } seq_state_t;

    typedef struct packed {
        logic passive_high_drive;
        logic passive_low_drive;
        logic active_high_drive;
        logic active_low_drive;
        logic rectifier_drive_e;
        logic rectifier_drive_f;
    } bridge_drive_t;

    localparam bridge_drive_t DRIVE_RESET = 6'h00;

endpackage

// ### verification/bridge_leg_model.sv
/*
 * behavioural model of one bridge leg as seen through its sense divider.
 * assumes the gate drivers follow the drive levels within one clock.
 */
`timescale 1ns/1ns

module bridge_leg_model #(
    parameter int DLY = 3
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // gate drive of the two switches
    input  wire logic high_i,
    input  wire logic low_i,
    // leg lacks energy to commutate
    input  wire logic stuck_i,
    // sense level, high near the input rail
    output logic      sense_o
);
    logic [7:0] cnt_q;

    // a driven leg follows its switch; a released leg swings across once
    // after DLY cycles, and a stuck leg never gets there
    always_ff @(posedge clk_i) begin
        if (rst_i || high_i || low_i) begin
            sense_o <= high_i;
            cnt_q   <= 8'h00;
        end else if (!stuck_i && cnt_q != 8'(DLY)) begin
            cnt_q <= cnt_q + 8'h01;
            if (cnt_q == 8'(DLY - 1)) begin
                sense_o <= ~sense_o;
            end
        end
    end
endmodule

// ### verification/phase_shift_bridge_sequencer_tb.sv
/*
 * self-checking bench of the bridge sequencer: walks both half cycles,
 * a forced commutation and the zero delay mode. assumes the leg model
 * stands in for the power stage.
 */
`timescale 1ns/1ns

module phase_shift_bridge_sequencer_tb;
    import psb_pkg::*;

    localparam int CYC = 12;
    logic          clk_i       = 1'b0;
    logic          rst_i       = 1'b1;
    logic          osc_clock_i = 1'b0;
    logic          phase_cmp_i = 1'b0;
    logic          tied_i      = 1'b0;
    logic          stuck_i     = 1'b0;
    logic          act_sense;
    logic          pas_sense;
    logic          phase_o;
    bridge_drive_t drive_o;
    int            mismatches   = 0;
    int            total_checks = 0;

    always #5 clk_i = ~clk_i;

    // timeout kept well above the leg delay so forcing is told apart
    phase_shift_bridge_sequencer #(.COMMUTATE_CYC(CYC)) phase_shift_bridge_sequencer_inst (
        .clk_i                    (clk_i),
        .rst_i                    (rst_i),
        .osc_clock_i              (osc_clock_i),
        .phase_cmp_i              (phase_cmp_i),
        .active_leg_sense_i       (act_sense),
        .passive_leg_sense_i      (pas_sense),
        .bus_voltage_sense_tied_i (tied_i),
        .drive_o                  (drive_o),
        .phase_o                  (phase_o)
    );

    bridge_leg_model #(.DLY(3)) active_leg_inst (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .high_i  (drive_o.active_high_drive),
        .low_i   (drive_o.active_low_drive),
        .stuck_i (stuck_i),
        .sense_o (act_sense)
    );

    bridge_leg_model #(.DLY(3)) passive_leg_inst (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .high_i  (drive_o.passive_high_drive),
        .low_i   (drive_o.passive_low_drive),
        .stuck_i (stuck_i),
        .sense_o (pas_sense)
    );

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // one-cycle pin pulse, then a bounded wait for the expected drive
    task automatic step(input logic osc, input logic cmp, input bridge_drive_t exp,
                        input logic ph, input int lim);
        int n;
        n = 0;
        osc_clock_i <= osc;
        phase_cmp_i <= cmp;
        while (drive_o !== exp && n < lim) begin
            @(posedge clk_i);
            #1;
            n++;
            if (n == 1 && (osc || cmp)) begin
                osc_clock_i <= 1'b0;
                phase_cmp_i <= 1'b0;
            end
        end
        total_checks++;
        if (drive_o !== exp || phase_o !== ph) begin
            mismatches++;
            $display("unexpected at %0t: drive %h phase %b", $time, drive_o, phase_o);
            if (drive_o !== exp) begin
                end_of_test;
            end
        end
    endtask

    task automatic test_reset;
        repeat (16) @(posedge clk_i);
        #1;
        total_checks++;
        if (drive_o !== DRIVE_RESET || phase_o !== PHASE_RESET) begin
            mismatches++;
            $display("unexpected at %0t: outputs live in reset", $time);
        end
        rst_i <= 1'b0;
        step(1'b0, 1'b0, 6'h25, 1'b0, 40);
    endtask

    // both half cycles with a responsive power stage
    task automatic test_full_cycle;
        step(1'b0, 1'b1, 6'h23, 1'b0, 10);
        step(1'b0, 1'b0, 6'h2b, 1'b0, 20);
        step(1'b1, 1'b0, 6'h0a, 1'b1, 10);
        step(1'b0, 1'b0, 6'h1a, 1'b1, 20);
        step(1'b0, 1'b1, 6'h13, 1'b1, 10);
        step(1'b0, 1'b0, 6'h17, 1'b1, 20);
        step(1'b1, 1'b0, 6'h05, 1'b0, 10);
        step(1'b0, 1'b0, 6'h25, 1'b0, 20);
    endtask

    // the active leg never arrives, so only the timeout can finish it
    task automatic test_forced;
        stuck_i <= 1'b1;
        step(1'b0, 1'b1, 6'h23, 1'b0, 10);
        // two cycles short of the limit the wait must still stand
        repeat (CYC - 2) @(posedge clk_i);
        #1;
        step(1'b0, 1'b0, 6'h23, 1'b0, 0);
        step(1'b0, 1'b0, 6'h2b, 1'b0, CYC + 8);
    endtask

    // legs still stuck, but the tied bus sense skips every wait
    task automatic test_zero_delay;
        tied_i <= 1'b1;
        step(1'b1, 1'b0, 6'h0a, 1'b1, 10);
        step(1'b0, 1'b0, 6'h1a, 1'b1, 3);
        step(1'b0, 1'b1, 6'h13, 1'b1, 10);
        step(1'b0, 1'b0, 6'h17, 1'b1, 3);
        tied_i  <= 1'b0;
        stuck_i <= 1'b0;
        step(1'b1, 1'b0, 6'h05, 1'b0, 10);
        step(1'b0, 1'b0, 6'h25, 1'b0, 20);
    endtask

    // clock lands with the comparator and is held until freewheel; both
    // legs stuck, so the passive transition is forced as well
    task automatic test_held_clock;
        stuck_i <= 1'b1;
        step(1'b1, 1'b1, 6'h23, 1'b0, 10);
        step(1'b0, 1'b0, 6'h2b, 1'b0, CYC + 8);
        step(1'b0, 1'b0, 6'h0a, 1'b1, 3);
        step(1'b0, 1'b0, 6'h1a, 1'b1, CYC + 8);
    endtask

    initial begin
        test_reset;
        test_full_cycle;
        test_forced;
        test_zero_delay;
        test_held_clock;
        end_of_test;
    end
endmodule
